// ---- rtl/pes_event_selector.sv ----
`timescale 1ns/1ps
module pes_event_selector #(
    parameter int NUM_CNT = 2,
    parameter int CNT_W   = 32,
    parameter int ADR_W   = 8
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       ce_i,
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    input  wire logic [ADR_W-1:0]           wb_adr_i,
    input  wire logic [3:0]                 wb_sel_i,
    input  wire logic [31:0]                wb_dat_i,
    output logic      [31:0]                wb_dat_o,
    output logic                            wb_ack_o,
    input  wire pes_pkg::pes_pipe_s         pipe_i,
    output logic      [NUM_CNT-1:0][3:0]    inc_o
);

    // ------------------------------------------------------------
    // Increment decoder
    // ------------------------------------------------------------
    // Occurrences of one selection in one cycle; zero when unlisted
    function automatic logic [3:0] f_increment(
        input pes_pkg::pes_sel_s  s,
        input pes_pkg::pes_pipe_s p,
        input logic               port_ok
    );
        logic [3:0] r;
        r = 4'h0;
        if (s.en) begin
            case (s.event_code)
                pes_pkg::EV_DISPATCH: begin
                    // One micro-op per port per cycle at most
                    if (port_ok) begin
                        case (s.umask)
                            pes_pkg::UM_PORT_THREE:
                                r = {3'h0, p.dispatch_port_three};
                            pes_pkg::UM_PORT_FOUR:
                                r = {3'h0, p.dispatch_port_four};
                            pes_pkg::UM_PORT_FIVE:
                                r = {3'h0, p.dispatch_port_five};
                            default:
                                r = 4'h0;
                        endcase
                    end
                end
                pes_pkg::EV_DECODE: begin
                    case (s.umask)
                        pes_pkg::UM_DECODED:
                            r = {1'b0, p.decoded_n};
                        pes_pkg::UM_COMPLEX:
                            r = {3'h0, p.complex_decoded};
                        default:
                            r = 4'h0;
                    endcase
                end
                pes_pkg::EV_STACK: begin
                    case (s.umask)
                        pes_pkg::UM_SP_SYNC:
                            r = {3'h0, p.stack_sync};
                        pes_pkg::UM_SP_ADD:
                            r = {3'h0, p.stack_add};
                        default:
                            r = 4'h0;
                    endcase
                end
                pes_pkg::EV_VECTOR: begin
                    // Store moves to memory are taken out
                    if (s.umask == pes_pkg::UM_NONE &&
                        p.vector_n > p.vector_store_move_n) begin
                        r = {1'b0, 3'(p.vector_n
                                      - p.vector_store_move_n)};
                    end
                end
                pes_pkg::EV_VEC_SAT: begin
                    if (s.umask == pes_pkg::UM_NONE) begin
                        r = {1'b0, p.vector_sat_n};
                    end
                end
                pes_pkg::EV_VEC_TYPE: begin
                    case (s.umask)
                        pes_pkg::UM_MUL:
                            r = {1'b0, p.vector_mul_n};
                        pes_pkg::UM_SHIFT:
                            r = {1'b0, p.vector_shift_n};
                        pes_pkg::UM_PACK:
                            r = {1'b0, p.vector_pack_n};
                        pes_pkg::UM_UNPACK:
                            r = {1'b0, p.vector_unpack_n};
                        pes_pkg::UM_LOGIC:
                            r = {1'b0, p.vector_logic_n};
                        default:
                            r = 4'h0;
                    endcase
                end
                default: begin
                    r = 4'h0;
                end
            endcase
        end
        return r;
    endfunction

    // Byte-lane merge for partial writes
    function automatic logic [31:0] f_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  sel
    );
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Bus request decode
    // ------------------------------------------------------------
    logic                     req;
    logic                     wr;
    logic [ADR_W-1:0]         adr;
    logic [NUM_CNT-1:0]       hit_sel;
    logic [NUM_CNT-1:0]       hit_cnt;
    logic                     hit_stat;

    // New request: strobe up and no answer given yet
    assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o & ce_i;
    assign wr       = req & wb_we_i;
    assign adr      = {wb_adr_i[ADR_W-1:2], 2'b00};
    assign hit_stat = (adr == ADR_W'(pes_pkg::STATUS_OFF));

    // Address match per counter pair
    always_comb begin
        for (int i = 0; i < NUM_CNT; i++) begin
            hit_sel[i] = (adr == ADR_W'(pes_pkg::SEL_BASE
                                        + 8'(i) * pes_pkg::PAIR_STRIDE));
            hit_cnt[i] = (adr == ADR_W'(pes_pkg::CNT_BASE
                                        + 8'(i) * pes_pkg::PAIR_STRIDE));
        end
    end

    // ------------------------------------------------------------
    // Selection registers
    // ------------------------------------------------------------
    logic [NUM_CNT-1:0][31:0] sel_reg;
    pes_pkg::pes_sel_s        sel_dec [NUM_CNT];

    // Software writes the event and unit mask per counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_reg <= {NUM_CNT{pes_pkg::SEL_RESET}};
        end else if (ce_i) begin
            for (int i = 0; i < NUM_CNT; i++) begin
                if (wr && hit_sel[i]) begin
                    sel_reg[i] <= f_merge(sel_reg[i], wb_dat_i, wb_sel_i);
                end
            end
        end
    end

    // Field extraction
    always_comb begin
        for (int i = 0; i < NUM_CNT; i++) begin
            sel_dec[i].en         = sel_reg[i][pes_pkg::SEL_EN_BIT];
            sel_dec[i].umask      = sel_reg[i][pes_pkg::SEL_UMASK_LSB +: 8];
            sel_dec[i].event_code = sel_reg[i][pes_pkg::SEL_EVENT_LSB +: 8];
        end
    end

    // ------------------------------------------------------------
    // Per-counter increments
    // ------------------------------------------------------------
    logic [NUM_CNT-1:0][3:0]  next_inc;
    logic [NUM_CNT-1:0]       bad_sel;

    // Port dispatch events are served by counter zero alone
    always_comb begin
        for (int i = 0; i < NUM_CNT; i++) begin
            next_inc[i] = f_increment(sel_dec[i], pipe_i, i == 0);
            bad_sel[i]  = sel_dec[i].en && (i != 0)
                          && sel_dec[i].event_code
                             == pes_pkg::EV_DISPATCH;
        end
    end

    // Registered increments toward the counters
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            inc_o <= '0;
        end else if (ce_i) begin
            inc_o <= next_inc;
        end
    end

    // ------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------
    logic [NUM_CNT-1:0][CNT_W-1:0] cnt;

    // Count from registered increments; a write loads value plus
    // the increment of the same cycle so no occurrence is lost
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_CNT; i++) begin
                cnt[i] <= CNT_W'(pes_pkg::CNT_RESET);
            end
        end else if (ce_i) begin
            for (int i = 0; i < NUM_CNT; i++) begin
                if (wr && hit_cnt[i]) begin
                    cnt[i] <= CNT_W'(f_merge(32'(cnt[i]), wb_dat_i,
                                             wb_sel_i))
                              + CNT_W'(inc_o[i]);
                end else begin
                    cnt[i] <= cnt[i] + CNT_W'(inc_o[i]);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Status
    // ------------------------------------------------------------
    logic [31:0] status;

    // Activity and unsupported-selection flags per counter
    always_comb begin
        status = 32'h0000_0000;
        for (int i = 0; i < NUM_CNT; i++) begin
            status[pes_pkg::STAT_ACT_LSB + i] = |inc_o[i];
            status[pes_pkg::STAT_BAD_LSB + i] = bad_sel[i];
        end
    end

    // ------------------------------------------------------------
    // Read mux and acknowledge
    // ------------------------------------------------------------
    logic [31:0] next_dat;

    // Unmapped addresses read zero and ignore writes
    always_comb begin
        next_dat = 32'h0000_0000;
        if (hit_stat) begin
            next_dat = status;
        end
        for (int i = 0; i < NUM_CNT; i++) begin
            if (hit_sel[i]) begin
                next_dat = sel_reg[i];
            end
            if (hit_cnt[i]) begin
                next_dat = 32'(cnt[i]);
            end
        end
    end

    // One-cycle answer, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else if (ce_i) begin
            wb_ack_o <= req;
        end
    end

    // Read data captured with the answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            wb_dat_o <= next_dat;
        end
    end

endmodule

// ---- rtl/pes_pkg.sv ----
// Contract
// - Event a1h counts port 3/4/5 dispatch cycles; the code counts it on counter 0 only, counter 1 adds zero
// - Port dispatch adds at most one per cycle
// - Event aah/01h counts every decoded instruction
// - Event aah/08h counts complex decodes, one max
// - Event abh/01h counts stack pointer syncs
// - Event abh/02h counts decoder stack additions
// - Vector count excludes register-to-memory store moves
// - Event b1h/00h counts saturating vector ops
// - Event b3h masks 01h/02h/04h: multiply, shift, pack
// - Event b3h masks 08h/10h: unpack, logical
// - Logical class is its own selectable count
package pes_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] SEL_BASE      = 8'h00;
    localparam logic [7:0] CNT_BASE      = 8'h04;
    localparam logic [7:0] PAIR_STRIDE   = 8'h08;
    localparam logic [7:0] STATUS_OFF    = 8'h20;

    // Selection register fields
    localparam int         SEL_EVENT_LSB = 0;
    localparam int         SEL_UMASK_LSB = 8;
    localparam int         SEL_EN_BIT    = 16;
    localparam logic [31:0] SEL_RESET    = 32'h0000_0000;
    localparam logic [31:0] CNT_RESET    = 32'h0000_0000;

    // Status register fields
    localparam int         STAT_ACT_LSB  = 0;
    localparam int         STAT_BAD_LSB  = 8;

    // ------------------------------------------------------------
    // Event codes and unit masks
    // ------------------------------------------------------------
    localparam logic [7:0] EV_DISPATCH   = 8'ha1;
    localparam logic [7:0] EV_DECODE     = 8'haa;
    localparam logic [7:0] EV_STACK      = 8'hab;
    localparam logic [7:0] EV_VECTOR     = 8'hb0;
    localparam logic [7:0] EV_VEC_SAT    = 8'hb1;
    localparam logic [7:0] EV_VEC_TYPE   = 8'hb3;

    localparam logic [7:0] UM_PORT_THREE = 8'h08;
    localparam logic [7:0] UM_PORT_FOUR  = 8'h10;
    localparam logic [7:0] UM_PORT_FIVE  = 8'h20;
    localparam logic [7:0] UM_DECODED    = 8'h01;
    localparam logic [7:0] UM_COMPLEX    = 8'h08;
    localparam logic [7:0] UM_SP_SYNC    = 8'h01;
    localparam logic [7:0] UM_SP_ADD     = 8'h02;
    localparam logic [7:0] UM_NONE       = 8'h00;
    localparam logic [7:0] UM_MUL        = 8'h01;
    localparam logic [7:0] UM_SHIFT      = 8'h02;
    localparam logic [7:0] UM_PACK       = 8'h04;
    localparam logic [7:0] UM_UNPACK     = 8'h08;
    localparam logic [7:0] UM_LOGIC      = 8'h10;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    // Per-cycle occurrence reports from the pipeline
    typedef struct packed {
        logic       dispatch_port_three;
        logic       dispatch_port_four;
        logic       dispatch_port_five;
        logic [2:0] decoded_n;
        logic       complex_decoded;
        logic       stack_sync;
        logic       stack_add;
        logic [2:0] vector_n;
        logic [2:0] vector_store_move_n;
        logic [2:0] vector_sat_n;
        logic [2:0] vector_mul_n;
        logic [2:0] vector_shift_n;
        logic [2:0] vector_pack_n;
        logic [2:0] vector_unpack_n;
        logic [2:0] vector_logic_n;
    } pes_pipe_s;

    // Decoded counter selection
    typedef struct packed {
        logic       en;
        logic [7:0] umask;
        logic [7:0] event_code;
    } pes_sel_s;

endpackage

// ---- sim/pes_event_selector_sva.sv ----
`timescale 1ns/1ps
module pes_event_selector_sva #(
    parameter int NUM_CNT = 2,
    parameter int CNT_W   = 32,
    parameter int ADR_W   = 8
) (
    input wire logic                    clk_i,
    input wire logic                    rst_i,
    input wire logic                    ce_i,
    input wire logic                    wb_cyc_i,
    input wire logic                    wb_stb_i,
    input wire logic                    wb_we_i,
    input wire logic [31:0]             wb_dat_o,
    input wire logic                    wb_ack_o,
    input wire pes_pkg::pes_pipe_s      pipe_i,
    input wire logic [NUM_CNT-1:0][3:0] inc_o
);
    // ----
    // Helpers
    // ----
    logic n_zero;
    logic inc_le1;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // No multi-count field active
    assign n_zero = ~|{pipe_i.decoded_n, pipe_i.vector_n,
        pipe_i.vector_sat_n, pipe_i.vector_mul_n, pipe_i.vector_shift_n,
        pipe_i.vector_pack_n, pipe_i.vector_unpack_n, pipe_i.vector_logic_n};
    // Every increment at most one
    always_comb begin
        inc_le1 = 1'b1;
        for (int i = 0; i < NUM_CNT; i++) begin
            if (inc_o[i] > 4'h1) inc_le1 = 1'b0;
        end
    end
    sequence s_req;
        wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o;
    endsequence
    sequence s_ans;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    // ----
    // Assertions
    // ----
    chk_ack_after_req: assert property (s_req |=> s_ans)
        else $error("ack missing or too long");
    chk_no_stray_ack: assert property (
        ce_i && !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    chk_ack_has_req: assert property (
        $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack rose without request");
    chk_read_hold: assert property (
        !wb_ack_o && !$past(rst_i) |-> $stable(wb_dat_o))
        else $error("read data moved outside answer");
    chk_write_keeps_dat: assert property (
        wb_ack_o && wb_we_i |-> $stable(wb_dat_o))
        else $error("write answer changed read data");
    chk_reset_clears: assert property (disable iff (1'b0)
        rst_i && ce_i |=> !wb_ack_o && inc_o == '0 && wb_dat_o == 32'h0)
        else $error("reset left state");
    chk_quiet_pipe: assert property (
        ce_i && pipe_i == '0 |=> inc_o == '0)
        else $error("increment without occurrence");
    chk_one_per_cycle: assert property (
        ce_i && n_zero |=> inc_le1)
        else $error("single event added more than one");
endmodule

bind pes_event_selector pes_event_selector_sva #(
    .NUM_CNT(NUM_CNT), .CNT_W(CNT_W), .ADR_W(ADR_W)) u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pipe_i(pipe_i), .inc_o(inc_o));

// ---- sim/pes_pipe_model.sv ----
`timescale 1ns/1ps
module pes_pipe_model (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               start_i,
    input  wire pes_pkg::pes_pipe_s pattern_i,
    input  wire logic [3:0]         len_i,
    output pes_pkg::pes_pipe_s      pipe_o
);
    logic [3:0] left;
    // Burst of one report per cycle, quiet between bursts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            left   <= 4'h0;
            pipe_o <= '0;
        end else if (start_i) begin
            left   <= len_i;
            pipe_o <= pattern_i;
        end else if (left > 4'h1) begin
            left <= left - 4'h1;
        end else begin
            left   <= 4'h0;
            pipe_o <= '0;
        end
    end
endmodule

// ---- sim/pes_event_selector_tb_top.sv ----
`timescale 1ns/1ps
module pes_event_selector_tb_top;
    logic               clk_i = 1'b0;
    logic               rst_i = 1'b1;
    logic               ce = 1'b1;
    logic               cyc = 1'b0;
    logic               stb = 1'b0;
    logic               we = 1'b0;
    logic [7:0]         adr = 8'h00;
    logic [31:0]        dat_w = 32'h0;
    logic [31:0]        rdat;
    logic               ack;
    logic               start = 1'b0;
    pes_pkg::pes_pipe_s pat = '0;
    pes_pkg::pes_pipe_s pipe;
    logic [1:0][3:0]    inc;
    logic [31:0]        rd;
    int                 errors = 0;
    int                 checks_done = 0;
    logic [15:0] keys [0:14] = '{16'h08a1, 16'h10a1, 16'h20a1, 16'h01aa,
        16'h08aa, 16'h01ab, 16'h02ab, 16'h00b0, 16'h00b1, 16'h01b3,
        16'h02b3, 16'h04b3, 16'h08b3, 16'h10b3, 16'h20b3};
    localparam pes_pkg::pes_pipe_s P1 = {3'b101, 3'h3, 3'b101, 3'h6, 3'h2,
        3'h5, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    localparam pes_pkg::pes_pipe_s P2 = {3'b010, 3'h7, 3'b010, 3'h1, 3'h3,
        3'h2, 3'h4, 3'h5, 3'h6, 3'h1, 3'h3};
    // Clock
    always #4 clk_i = ~clk_i;
    pes_event_selector #(.NUM_CNT(2), .CNT_W(32), .ADR_W(8)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(dat_w), .wb_dat_o(rdat), .wb_ack_o(ack), .pipe_i(pipe),
        .inc_o(inc));
    pes_pipe_model model (.clk_i(clk_i), .rst_i(rst_i), .start_i(start),
        .pattern_i(pat), .len_i(4'h5), .pipe_o(pipe));
    // ----
    // Shared tasks
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (ack !== 1'b1) begin
            errors++;
            print_verdict();
        end
    endtask
    // Expected increment per cycle for one selection
    function automatic logic [3:0] ref_inc(int c, logic [16:0] s,
                                           pes_pkg::pes_pipe_s p);
        logic [3:0] r;
        r = 4'h0;
        if (s[16] && !(c != 0 && s[7:0] == 8'ha1)) case (s[15:0])
            16'h08a1: r = {3'h0, p.dispatch_port_three};
            16'h10a1: r = {3'h0, p.dispatch_port_four};
            16'h20a1: r = {3'h0, p.dispatch_port_five};
            16'h01aa: r = {1'b0, p.decoded_n};
            16'h08aa: r = {3'h0, p.complex_decoded};
            16'h01ab: r = {3'h0, p.stack_sync};
            16'h02ab: r = {3'h0, p.stack_add};
            16'h00b0: if (p.vector_n > p.vector_store_move_n)
                r = {1'b0, p.vector_n - p.vector_store_move_n};
            16'h00b1: r = {1'b0, p.vector_sat_n};
            16'h01b3: r = {1'b0, p.vector_mul_n};
            16'h02b3: r = {1'b0, p.vector_shift_n};
            16'h04b3: r = {1'b0, p.vector_pack_n};
            16'h08b3: r = {1'b0, p.vector_unpack_n};
            16'h10b3: r = {1'b0, p.vector_logic_n};
            default: r = 4'h0;
        endcase
        return r;
    endfunction
    // Program one selection, run a burst, judge increment and count
    task automatic run_sel(input int c, input logic [16:0] s,
                           input pes_pkg::pes_pipe_s p);
        logic [3:0] e;
        logic [7:0] o;
        e = ref_inc(c, s, p);
        o = 8'(8 * c);
        bus(1'b1, o + 8'h04, 32'hffff_fffd);
        bus(1'b1, o, {15'h0, s});
        bus(1'b0, o, 32'h0);
        check(rd, {15'h0, s});
        @(posedge clk_i);
        pat <= p;
        start <= 1'b1;
        @(posedge clk_i);
        start <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        check({28'h0, inc[c]}, {28'h0, e});
        repeat (8) @(posedge clk_i);
        bus(1'b0, o + 8'h04, 32'h0);
        check(rd, 32'hffff_fffd + 32'(5 * e));
        bus(1'b0, 8'h20, 32'h0);
        check({31'h0, rd[9]}, {31'h0, c == 1 && s[7:0] == 8'ha1});
        bus(1'b1, o, 32'h0);
    endtask
    // ----
    // Scenarios
    // ----
    task automatic test_reset_map();
        for (int a = 0; a <= 8'h20; a += 4) begin
            bus(1'b0, 8'(a), 32'h0);
            check(rd, 32'h0);
        end
        bus(1'b1, 8'h30, 32'hffff_ffff);
        bus(1'b0, 8'h30, 32'h0);
        check(rd, 32'h0);
    endtask
    task automatic test_all_events();
        for (int i = 0; i < 15; i++) begin
            run_sel(0, {1'b1, keys[i]}, P1);
            run_sel(0, {1'b1, keys[i]}, P2);
        end
        run_sel(0, {1'b0, 16'h01aa}, P1);
    endtask
    task automatic test_counter_one();
        run_sel(1, {1'b1, 16'h08a1}, P1);
        run_sel(1, {1'b1, 16'h02b3}, P2);
    endtask
    // Clock enable low freezes increment, count and bus answer
    task automatic test_clock_enable();
        bus(1'b1, 8'h04, 32'h0000_0010);
        bus(1'b1, 8'h00, 32'h0001_02ab);
        @(posedge clk_i);
        pat <= P1;
        start <= 1'b1;
        @(posedge clk_i);
        start <= 1'b0;
        @(posedge clk_i);
        ce <= 1'b0;
        fork
            begin
                repeat (8) @(posedge clk_i);
                check({28'h0, inc[0]}, 32'h0000_0001);
                ce <= 1'b1;
            end
            begin
                bus(1'b0, 8'h04, 32'h0);
            end
        join
        check(rd, 32'h0000_0010);
        bus(1'b0, 8'h04, 32'h0);
        check(rd, 32'h0000_0011);
        bus(1'b1, 8'h00, 32'h0);
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        test_reset_map();
        test_all_events();
        test_counter_one();
        test_clock_enable();
        print_verdict();
    end
endmodule
